/* File: verilog/ofr_pkg.sv */
// Constants, register map and state codes for the output fault restart supervisor
package ofr_pkg;
  // Clock and the 1 ms timebase
  localparam int CLK_NS       = 20;
  localparam int TICK_NS      = 1000000;
  localparam int TICK_CYC     = TICK_NS / CLK_NS;
  // Times in their own units, then in 1 ms ticks
  localparam int GRACE_S      = 20;
  localparam int GRACE_MS     = GRACE_S * 1000;
  localparam int OV_DLY_S     = 1;
  localparam int OV_DLY_MS    = OV_DLY_S * 1000;
  localparam int OV_WIN_MIN   = 1;
  localparam int OV_WIN_MS    = OV_WIN_MIN * 60000;
  localparam int AC_DLY_S     = 10;
  localparam int AC_DLY_MS    = AC_DLY_S * 1000;
  localparam int PGW_LEAD_MS  = 3;
  localparam int AUX_LEAD_MS  = 450;
  localparam int BLINK_BIT    = 8;
  localparam logic [1:0] OV_MAX = 2'h3;
  // Analog thresholds as delivered by the converters
  localparam logic [11:0] VPROG_MIN_MV = 12'h064;
  localparam logic [11:0] VPROG_MAX_MV = 12'hbb8;
  localparam logic [15:0] VOUT_DEF_MV  = 16'hcb20;
  localparam logic [15:0] VLIM_MV      = 16'h2710;
  localparam logic [8:0]  VIN_LOW_V    = 9'h050;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_VSET  = 8'h04;
  localparam logic [7:0] REG_STAT  = 8'h08;
  localparam logic [7:0] REG_ALARM = 8'h0c;
  localparam logic [7:0] REG_STAT2 = 8'h10;
  // Control fields and reset value
  localparam int CTRL_OP_ON    = 0;
  localparam int CTRL_OC_LATCH = 1;
  localparam int CTRL_OT_LATCH = 2;
  localparam logic [2:0] CTRL_RST = 3'h1;
  // Alarm bit positions
  localparam int AL_OV = 0;
  localparam int AL_OC = 1;
  localparam int AL_OT = 2;
  localparam int AL_IL = 3;
  // Setpoint source codes
  localparam logic [1:0] SRC_DEF = 2'h0;
  localparam logic [1:0] SRC_PIN = 2'h1;
  localparam logic [1:0] SRC_FW  = 2'h2;
  typedef enum logic [2:0] {
    ST_ACWAIT = 3'b000,
    ST_OFF    = 3'b001,
    ST_ON     = 3'b010,
    ST_RETRY  = 3'b011,
    ST_LATCH  = 3'b100,
    ST_PGW    = 3'b101
  } ofr_state_t;
endpackage

/* File: verilog/ofr_supervisor.sv */
// Output fault restart supervisor: setpoint arbitration, restart and indication logic
// How it works
// - Pin level in range sets the setpoint
// - Open or high pin gives default voltage
// - Firmware setpoint locks out pin until repower
// - Overcurrent ignored for grace after power-up
// - Limit above threshold blinks output indicator
// - Limit below threshold with auto-retry hiccups
// - Latched shutdown keeps output indicator dark
// - Overcurrent and overtemperature auto-restart by default
// - Overvoltage retries thrice, one second apart, latches
// - Few shutdowns in window clear counter
// - Latch setting keeps unit off after fault
// - Pin cycle, operation cycle, reconfig restart
// - Restart clears alarms, sets restart flag
// - Wait restart delay after input returns
// - Warning leads main output loss by margin
// - Standby output leads main output start
// - Input indicator blinks at low line
// - Reversed interlock shuts output promptly
//
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module ofr_supervisor #(
  parameter int TICK_CYC = ofr_pkg::TICK_CYC
) (
  // Clock and reset
  input  wire  logic        sys_clk,
  input  wire  logic        rst,
  // APB slave
  input  wire  logic [7:0]  paddr,
  input  wire  logic        psel,
  input  wire  logic        penable,
  input  wire  logic        pwrite,
  input  wire  logic [31:0] pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  // Control pins from the system
  input  wire  logic        onoff_n_pin,
  input  wire  logic        interlock_pin,
  // Power stage sensing
  input  wire  logic        ac_ok,
  input  wire  logic [8:0]  vin_v,
  input  wire  logic [15:0] vout_mv,
  input  wire  logic [11:0] vprog_mv,
  input  wire  logic        in_limit,
  input  wire  logic        ov_trip,
  input  wire  logic        oc_trip,
  input  wire  logic        ot_trip,
  // Power stage control and indication
  output logic              main_en,
  output logic [15:0]       vout_set_mv,
  output logic [1:0]        vout_src,
  output logic              standby_aux_output,
  output logic              output_good_warning,
  output logic              led_out,
  output logic              led_in
);

  ofr_pkg::ofr_state_t st_q, st_d;
  logic [31:0] div_q;
  logic        tick_q;
  logic [15:0] ms_q, tmr_q, aux_age_q, grace_q, win_q;
  logic [1:0]  ov_cnt_q;
  logic [2:0]  sync_q [2];
  logic        pin_on_q, il_ok_q;
  logic [2:0]  ctrl_q;
  logic [15:0] vset_q;
  logic        fw_ctrl_q, restart_pend_q, restart_ok_q, off_seen_q;
  logic [3:0]  alarm_q;

  // Pin synchronisers; a level is taken only when stages two and three agree
  wire [1:0] pin_raw = {interlock_pin, ~onoff_n_pin};
  for (genvar i = 0; i < 2; i++) begin : g_sync
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        sync_q[i] <= 3'h0;
      end else begin
        sync_q[i] <= {sync_q[i][1:0], pin_raw[i]};
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_on_q <= 1'b0;
      il_ok_q  <= 1'b0;
    end else begin
      if (sync_q[0][2] == sync_q[0][1]) pin_on_q <= sync_q[0][2];
      if (sync_q[1][2] == sync_q[1][1]) il_ok_q  <= sync_q[1][2];
    end
  end

  // APB decode; answer comes one cycle after setup so outputs stay registered
  wire setup   = psel & ~penable;
  wire acc     = psel & penable & pready;
  wire wr      = acc & pwrite;
  wire hit_ctl = (paddr == ofr_pkg::REG_CTRL);
  wire hit_vs  = (paddr == ofr_pkg::REG_VSET);
  wire hit_st  = (paddr == ofr_pkg::REG_STAT);
  wire hit_al  = (paddr == ofr_pkg::REG_ALARM);
  wire hit_s2  = (paddr == ofr_pkg::REG_STAT2);
  wire mapped  = hit_ctl | hit_vs | hit_st | hit_al | hit_s2;
  wire wr_ctl  = wr & hit_ctl;
  wire [31:0] rd_mux =
      hit_ctl ? {29'h0, ctrl_q} :
      hit_vs  ? {16'h0, vset_q} :
      hit_st  ? {24'h0, fw_ctrl_q, grace_q != 16'h0, ov_cnt_q, 1'b0, st_q} :
      hit_al  ? {28'h0, alarm_q} :
      hit_s2  ? {31'h0, restart_ok_q} : 32'h0;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      if (setup) prdata <= rd_mux;
    end
  end

  // 1 ms timebase; all long waits count these ticks
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      div_q  <= 32'h0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (div_q == 32'(TICK_CYC - 1));
      div_q  <= (div_q == 32'(TICK_CYC - 1)) ? 32'h0 : div_q + 32'h1;
    end
  end

  // Fault and enable terms seen by the state machine
  wire enable    = pin_on_q & ctrl_q[ofr_pkg::CTRL_OP_ON] & il_ok_q;
  wire above_lim = (vout_mv > ofr_pkg::VLIM_MV);
  wire grace     = (grace_q != 16'h0);
  wire oc_fault  = oc_trip & ~grace;
  wire lim_low   = in_limit & ~above_lim & ~grace;
  wire oc_latch  = ctrl_q[ofr_pkg::CTRL_OC_LATCH];
  wire ot_latch  = ctrl_q[ofr_pkg::CTRL_OT_LATCH];
  wire ov_latch  = (ov_cnt_q == ofr_pkg::OV_MAX);
  wire tmr_ov    = (tmr_q > 16'(ofr_pkg::OV_DLY_MS)); // First tick may be partial
  // Reconfiguring any latch bit back to restart counts as a restart
  wire cfg_rst   = wr_ctl & ((oc_latch & ~pwdata[ofr_pkg::CTRL_OC_LATCH]) |
                             (ot_latch & ~pwdata[ofr_pkg::CTRL_OT_LATCH]));
  wire ov_event  = (st_q == ofr_pkg::ST_ON) & ac_ok & il_ok_q & enable & ov_trip;

  // Next-state selection; input loss outranks every fault
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ofr_pkg::ST_ACWAIT: begin
        if (ac_ok && tmr_q > 16'(ofr_pkg::AC_DLY_MS) &&
            aux_age_q >= 16'(ofr_pkg::AUX_LEAD_MS)) st_d = ofr_pkg::ST_OFF;
      end
      ofr_pkg::ST_OFF: begin
        if (enable) st_d = ofr_pkg::ST_ON;
      end
      ofr_pkg::ST_ON: begin
        if (!enable) begin
          st_d = ofr_pkg::ST_OFF;
        end else if (ov_trip) begin
          st_d = ov_latch ? ofr_pkg::ST_LATCH : ofr_pkg::ST_RETRY;
        end else if ((ot_trip && ot_latch) || ((oc_fault || lim_low) && oc_latch)) begin
          st_d = ofr_pkg::ST_LATCH;
        end else if (ot_trip || oc_fault || lim_low) begin
          st_d = ofr_pkg::ST_RETRY;
        end
      end
      ofr_pkg::ST_RETRY: begin
        if (!enable) st_d = ofr_pkg::ST_OFF;
        else if (tmr_ov) st_d = ofr_pkg::ST_ON;
      end
      ofr_pkg::ST_LATCH: begin
        if (cfg_rst || (off_seen_q && enable)) st_d = ofr_pkg::ST_OFF;
      end
      ofr_pkg::ST_PGW: begin
        if (tmr_q > 16'(ofr_pkg::PGW_LEAD_MS)) st_d = ofr_pkg::ST_ACWAIT;
      end
      default: st_d = ofr_pkg::ST_ACWAIT;
    endcase
    if (!ac_ok && st_q == ofr_pkg::ST_ON) st_d = ofr_pkg::ST_PGW;
    else if (!ac_ok && st_q != ofr_pkg::ST_PGW) st_d = ofr_pkg::ST_ACWAIT;
  end

  // State register and per-state tick timer; input absence holds the timer at zero in ST_ACWAIT only
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q  <= ofr_pkg::ST_ACWAIT;
      tmr_q <= 16'h0;
    end else begin
      st_q <= st_d;
      if (st_d != st_q || (st_q == ofr_pkg::ST_ACWAIT && !ac_ok)) tmr_q <= 16'h0;
      else if (tick_q && tmr_q != 16'hffff) tmr_q <= tmr_q + 16'h1;
    end
  end

  // Aux age, free ms counter and startup grace
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      aux_age_q <= 16'h0;
      ms_q      <= 16'h0;
      grace_q   <= 16'h0;
    end else begin
      if (tick_q) ms_q <= ms_q + 16'h1;
      if (!ac_ok) aux_age_q <= 16'h0;
      else if (tick_q && aux_age_q < 16'(ofr_pkg::AUX_LEAD_MS)) aux_age_q <= aux_age_q + 16'h1;
      if (st_q == ofr_pkg::ST_ACWAIT) grace_q <= 16'(ofr_pkg::GRACE_MS);
      else if (tick_q && grace) grace_q <= grace_q - 16'h1;
    end
  end

  // Overvoltage shutdown count inside a one-minute window
  // reset clears history
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ov_cnt_q <= 2'h0;
      win_q    <= 16'h0;
    end else if (ov_event && !ov_latch) begin
      ov_cnt_q <= ov_cnt_q + 2'h1;
    end else if (tick_q && ov_cnt_q != 2'h0) begin
      if (win_q == 16'(ofr_pkg::OV_WIN_MS - 1)) begin
        ov_cnt_q <= 2'h0;
        win_q    <= 16'h0;
      end else begin
        win_q <= win_q + 16'h1;
      end
    end
  end

  // Software registers; hardware sets win over software clears
  wire restart_done = restart_pend_q & (st_q != ofr_pkg::ST_ON) & (st_d == ofr_pkg::ST_ON);
  wire [3:0] al_set = {(st_q == ofr_pkg::ST_ON) & ~il_ok_q, ot_trip, oc_fault, ov_trip};
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_q       <= ofr_pkg::CTRL_RST;
      vset_q       <= ofr_pkg::VOUT_DEF_MV;
      fw_ctrl_q    <= 1'b0;
      alarm_q      <= 4'h0;
      restart_ok_q <= 1'b0;
    end else begin
      if (wr_ctl) ctrl_q <= pwdata[2:0];
      if (wr && hit_vs) begin
        vset_q    <= pwdata[15:0];
        fw_ctrl_q <= 1'b1;
      end
      if (restart_done) alarm_q <= al_set;
      else alarm_q <= (alarm_q & ~((wr && hit_al) ? pwdata[3:0] : 4'h0)) | al_set;
      if (restart_done) restart_ok_q <= 1'b1;
      else if (wr && hit_s2 && pwdata[0]) restart_ok_q <= 1'b0;
    end
  end

  // Restart bookkeeping: an off must be seen inside latch before an on restarts
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      off_seen_q     <= 1'b0;
      restart_pend_q <= 1'b0;
    end else begin
      if (st_q != ofr_pkg::ST_LATCH) off_seen_q <= 1'b0;
      else if (!enable) off_seen_q <= 1'b1;
      if (st_q == ofr_pkg::ST_LATCH && st_d == ofr_pkg::ST_OFF) restart_pend_q <= 1'b1;
      else if (restart_done || st_q == ofr_pkg::ST_ACWAIT) restart_pend_q <= 1'b0;
    end
  end

  // Setpoint arbitration
  wire vprog_ok = (vprog_mv >= ofr_pkg::VPROG_MIN_MV) && (vprog_mv <= ofr_pkg::VPROG_MAX_MV);
  wire [1:0] src_d = fw_ctrl_q ? ofr_pkg::SRC_FW :
                     vprog_ok  ? ofr_pkg::SRC_PIN : ofr_pkg::SRC_DEF;
  wire blink = ms_q[ofr_pkg::BLINK_BIT];

  // Registered outputs toward the power stage and front panel
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      vout_src            <= ofr_pkg::SRC_DEF;
      vout_set_mv         <= ofr_pkg::VOUT_DEF_MV;
      main_en             <= 1'b0;
      standby_aux_output  <= 1'b0;
      output_good_warning <= 1'b0;
      led_out             <= 1'b0;
      led_in              <= 1'b0;
    end else begin
      vout_src    <= src_d;
      vout_set_mv <= fw_ctrl_q ? vset_q :
                     vprog_ok  ? {4'h0, vprog_mv} : ofr_pkg::VOUT_DEF_MV;
      main_en <= (st_d == ofr_pkg::ST_ON) || (st_d == ofr_pkg::ST_PGW);
      standby_aux_output  <= ac_ok;
      output_good_warning <= ~ac_ok;
      led_out <= (st_q == ofr_pkg::ST_ON) & ~(in_limit & above_lim & blink);
      led_in  <= (vin_v < ofr_pkg::VIN_LOW_V) ? blink : ac_ok;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_pin_setpoint: assert property (!fw_ctrl_q && vprog_ok |=>
    vout_src == ofr_pkg::SRC_PIN && vout_set_mv == {4'h0, $past(vprog_mv)})
    else $error("pin setpoint not applied");
  a_default_set: assert property (!fw_ctrl_q && !vprog_ok |=>
    vout_set_mv == ofr_pkg::VOUT_DEF_MV)
    else $error("default setpoint not applied");
  a_fw_lock: assert property ($rose(fw_ctrl_q) |-> ##1 fw_ctrl_q [*8] ##0
    vout_src == ofr_pkg::SRC_FW)
    else $error("firmware control lost");
  a_grace_hold: assert property (st_q == ofr_pkg::ST_ON && grace && oc_trip && enable
    && ac_ok && !ov_trip && !ot_trip && !in_limit |=> st_q == ofr_pkg::ST_ON)
    else $error("overcurrent acted during grace");
  a_latch_dark: assert property (st_q == ofr_pkg::ST_LATCH |=> !led_out)
    else $error("output indicator lit in latch");
  a_ov_latch: assert property (ov_event && ov_latch |=> st_q == ofr_pkg::ST_LATCH)
    else $error("fourth overvoltage did not latch");
  a_win_clear: assert property (tick_q && ov_cnt_q != 2'h0 && !ov_event &&
    win_q == 16'(ofr_pkg::OV_WIN_MS - 1) |=> ov_cnt_q == 2'h0 && win_q == 16'h0)
    else $error("window did not clear count");
  a_restart_flag: assert property (restart_done |=> restart_ok_q &&
    st_q == ofr_pkg::ST_ON && !restart_pend_q)
    else $error("restart flag not set");
  a_pgw_lead: assert property ($rose(output_good_warning) && $past(st_q) == ofr_pkg::ST_ON
    |-> main_en ##1 main_en)
    else $error("warning not ahead of output loss");
  a_il_off: assert property (st_q == ofr_pkg::ST_ON && !il_ok_q && ac_ok |=>
    !main_en && st_q == ofr_pkg::ST_OFF)
    else $error("interlock did not shut output");

endmodule

/* File: test/ofr_host.sv */
// Host-side model of the on/off and interlock pins
`timescale 1ns/1ps
module ofr_host #(
  parameter int MIN_OFF = 10000
) (
  // Clock
  input  wire logic sys_clk,
  // Control pins towards the supervisor
  output logic      onoff_n_pin,
  output logic      interlock_pin
);
  // Pins rest with the unit commanded on and the interlock made
  initial begin
    onoff_n_pin   = 1'b0;
    interlock_pin = 1'b1;
  end

  // off then on toggle
  // Off time is clamped up, since a short toggle is a host fault
  task automatic pin_cycle(input int off_cyc);
    @(posedge sys_clk);
    onoff_n_pin <= 1'b1;
    repeat ((off_cyc > MIN_OFF) ? off_cyc : MIN_OFF) @(posedge sys_clk);
    onoff_n_pin <= 1'b0;
  endtask

  // Interlock opened or made just after an edge
  task automatic set_interlock(input logic v);
    @(posedge sys_clk);
    interlock_pin <= v;
  endtask
endmodule

/* File: test/tb_ofr_supervisor.sv */
// Self-checking testbench for the output fault restart supervisor
`timescale 1ns/1ps
module tb_ofr_supervisor;
  // Off time for a synchronised restart lets bias and soft start fully reset
  localparam int T           = 2;
  localparam int LIM         = 85000;
  localparam int SYNC_OFF_MS = 20000;
  localparam logic [11:0] PV [5] = '{12'h000, 12'h064, 12'hbb8, 12'hbb9, 12'h7d0};
  logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic        ac_ok, in_limit, ov_trip, oc_trip, ot_trip, main_en, aux, warn;
  logic        onoff_n_pin, interlock_pin, led_out, led_in, inr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [8:0]  vin_v;
  logic [15:0] vout_mv, vout_set_mv;
  logic [11:0] vprog_mv;
  logic [1:0]  vout_src;
  int          num_errors, n_tests, n, t0;
  int          cyc = 0;

  // Short tick keeps the 10 s start delay inside the run budget
  ofr_supervisor #(.TICK_CYC(T)) i_dut (
    .sys_clk(sys_clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .onoff_n_pin(onoff_n_pin), .interlock_pin(interlock_pin), .ac_ok(ac_ok), .vin_v(vin_v),
    .vout_mv(vout_mv), .vprog_mv(vprog_mv), .in_limit(in_limit), .ov_trip(ov_trip),
    .oc_trip(oc_trip), .ot_trip(ot_trip), .main_en(main_en), .vout_set_mv(vout_set_mv),
    .vout_src(vout_src), .standby_aux_output(aux), .output_good_warning(warn),
    .led_out(led_out), .led_in(led_in));

  ofr_host #(.MIN_OFF(2000 * T)) i_host (
    .sys_clk(sys_clk), .onoff_n_pin(onoff_n_pin), .interlock_pin(interlock_pin));

  // 50 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    if (num_errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // APB transfer: held until pready is sampled high at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Bounded only by the global timeout
  task automatic wait_en(input logic v);
    n = 0;
    while (main_en !== v) begin
      @(posedge sys_clk);
      n++;
    end
  endtask

  // Counts indicator changes over 600 ms, enough for two half periods
  task automatic blinks();
    logic [1:0] p;
    n = 0;
    p = {led_out, led_in};
    repeat (600 * T) begin
      @(posedge sys_clk);
      if ({led_out, led_in} !== p) n++;
      p = {led_out, led_in};
    end
  endtask

  // Pulse one trip input for a single cycle
  task automatic trip(input int k);
    @(posedge sys_clk);
    if (k == 0) ov_trip <= 1'b1; else ot_trip <= 1'b1;
    @(posedge sys_clk);
    ov_trip <= 1'b0;
    ot_trip <= 1'b0;
  endtask

  // A hang counts as a mismatch
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIM) begin
      num_errors++;
      tally_and_finish();
    end
  end

  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata, ac_ok, vin_v} = {1'b1, 53'h0};
    {vout_mv, vprog_mv, in_limit, ov_trip, oc_trip, ot_trip} = 32'h0;
    num_errors = 0;
    n_tests = 0;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    // Setpoint source across the programming range edges
    foreach (PV[i]) begin
      vprog_mv <= PV[i];
      repeat (3) @(posedge sys_clk);
      inr = (PV[i] >= ofr_pkg::VPROG_MIN_MV) && (PV[i] <= ofr_pkg::VPROG_MAX_MV);
      chk("vout_src", vout_src, inr ? ofr_pkg::SRC_PIN : ofr_pkg::SRC_DEF);
      chk("vout_set", vout_set_mv, inr ? {4'h0, PV[i]} : ofr_pkg::VOUT_DEF_MV);
    end
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped_err", err, 32'h1);
    apb(1'b0, ofr_pkg::REG_CTRL, 32'h0);
    chk("ctrl_reset", rd, ofr_pkg::CTRL_RST);
    // Low line start: aux first, input indicator blinking
    vin_v <= 9'h046;
    ac_ok <= 1'b1;
    t0 = cyc;
    repeat (2) @(posedge sys_clk);
    chk("aux", aux, 32'h1);
    chk("warn_idle", warn, 32'h0);
    blinks();
    chk("led_in_blink", n >= 2, 32'h1);
    vin_v <= 9'h0e6;
    wait_en(1'b1);
    chk("ac_delay", (cyc - t0) >= ofr_pkg::AC_DLY_MS * T, 32'h1);
    chk("aux_lead", (cyc - t0) > ofr_pkg::AUX_LEAD_MS * T, 32'h1);
    repeat (2) @(posedge sys_clk);
    chk("led_out_on", led_out, 32'h1);
    // Overcurrent inside the start grace
    oc_trip <= 1'b1;
    repeat (100) @(posedge sys_clk);
    chk("grace_on", main_en, 32'h1);
    apb(1'b0, ofr_pkg::REG_STAT, 32'h0);
    chk("grace_flag", rd[6], 32'h1);
    oc_trip <= 1'b0;
    in_limit <= 1'b1;
    vout_mv <= ofr_pkg::VOUT_DEF_MV;
    blinks();
    chk("led_out_blink", n >= 2, 32'h1);
    in_limit <= 1'b0;
    // Three overvoltage retries, the fourth latches
    for (int i = 0; i < 4; i++) begin
      trip(0);
      wait_en(1'b0);
      if (i < 3) begin
        wait_en(1'b1);
        chk("ov_retry", n >= ofr_pkg::OV_DLY_MS * T, 32'h1);
      end
    end
    apb(1'b0, ofr_pkg::REG_STAT, 32'h0);
    chk("ov_latch", rd[2:0], ofr_pkg::ST_LATCH);
    chk("ov_count3", rd[5:4], 32'h3);
    apb(1'b0, ofr_pkg::REG_ALARM, 32'h0);
    chk("alarm_ov", rd, 32'h1);
    repeat (4) @(posedge sys_clk);
    chk("led_latched", led_out, 32'h0);
    i_host.pin_cycle(SYNC_OFF_MS * T);
    wait_en(1'b1);
    apb(1'b0, ofr_pkg::REG_STAT2, 32'h0);
    chk("restart_flag", rd[0], 32'h1);
    apb(1'b0, ofr_pkg::REG_ALARM, 32'h0);
    chk("alarms_clear", rd, 32'h0);
    // Overtemperature with latch-off, then reconfigured to restart
    apb(1'b1, ofr_pkg::REG_CTRL, 32'h5);
    trip(1);
    wait_en(1'b0);
    apb(1'b0, ofr_pkg::REG_STAT, 32'h0);
    chk("ot_latch", rd[2:0], ofr_pkg::ST_LATCH);
    apb(1'b1, ofr_pkg::REG_CTRL, 32'h1);
    wait_en(1'b1);
    chk("reconfig_fast", n < 20, 32'h1);
    trip(1);
    wait_en(1'b0);
    wait_en(1'b1);
    chk("ot_auto", n >= ofr_pkg::OV_DLY_MS * T, 32'h1);
    // Hiccup: limit below the threshold once the grace is over, auto-retry selected
    in_limit <= 1'b1;
    vout_mv  <= 16'h1388;
    wait_en(1'b0);
    repeat (2) @(posedge sys_clk);
    chk("hiccup_dark", led_out, 32'h0);
    wait_en(1'b1);
    chk("hiccup_off", n >= ofr_pkg::OV_DLY_MS * T, 32'h1);
    in_limit <= 1'b0;
    vout_mv  <= ofr_pkg::VOUT_DEF_MV;
    wait_en(1'b0);
    wait_en(1'b1);
    chk("hiccup_again", n >= ofr_pkg::OV_DLY_MS * T, 32'h1);
    // Firmware setpoint takes over from the pin
    apb(1'b1, ofr_pkg::REG_VSET, 32'h9c40);
    vprog_mv <= 12'h3e8;
    repeat (3) @(posedge sys_clk);
    chk("fw_src", vout_src, ofr_pkg::SRC_FW);
    chk("fw_set", vout_set_mv, 32'h9c40);
    i_host.set_interlock(1'b0);
    wait_en(1'b0);
    chk("interlock_off", n < 10, 32'h1);
    apb(1'b0, ofr_pkg::REG_ALARM, 32'h0);
    chk("alarm_il_ot", rd, 32'hc);
    apb(1'b1, ofr_pkg::REG_ALARM, 32'hc);
    apb(1'b0, ofr_pkg::REG_ALARM, 32'h0);
    chk("alarm_w1c", rd, 32'h0);
    i_host.set_interlock(1'b1);
    wait_en(1'b1);
    // AC loss: warning leads the output drop
    ac_ok <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk("warn_lost", warn, 32'h1);
    wait_en(1'b0);
    chk("warn_lead", n >= ofr_pkg::PGW_LEAD_MS * T, 32'h1);
    // Power cycle returns control to the pin and clears history
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("pin_back", vout_src, ofr_pkg::SRC_PIN);
    apb(1'b0, ofr_pkg::REG_STAT, 32'h0);
    chk("ov_count", rd[5:4], 32'h0);
    tally_and_finish();
  end
endmodule
